// ===== src/bcms_sequencer.sv
// Behaviour
// - power-down release settles output within 3 ms
// - power-up enters normal, settled within 3 ms
// - ratio change resettles output within 1 ms
// - clock-stop release restarts clean edges in 10 ns
// - phase returns near pre-stop value in 20 cycles
// - clock-stop entry disables output within 5 ns
// - power-down entry completes within 1 ms
// - phase lock reached within 5 ms of settling
// - lock only while measured error is zero whole cycles; the +/-100 ps window rounds down
// - spread-spectrum tracking keeps error inside window
`timescale 1ns/1ps
`default_nettype none
module bcms_sequencer import bcms_pkg::*; #(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned RATIO_CYCLES = RATIO_CYC,
  parameter int unsigned LOCK_CYCLES = LOCK_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // mode pins
  input wire logic power_down_n,
  input wire logic clock_stop_n,
  input wire logic ratio_select_0,
  input wire logic ratio_select_1,
  input wire logic spread_spectrum_reference,
  // divided clocks from the gear logic
  input wire logic processor_clock_divided,
  input wire logic channel_clock_divided,
  // bus clock pair
  output logic bus_clock_pair_p,
  output logic bus_clock_pair_n,
  // status
  output logic clock_stopped_state,
  output logic powered_down,
  output logic output_settled,
  output logic phase_restored,
  output logic distributed_loop_lock,
  output logic lock_timeout
);

  typedef struct packed {
    bcms_state_e st;
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PIN_N-1:0] filt;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] lock_timer;
    logic [HALF_W-1:0] half_cnt;
    logic [1:0] ratio;
    logic clk_p;
    logic clk_en;
    logic adv;
    logic slip;
    logic settled;
    logic restored;
    logic lock;
    logic lock_to;
    logic out_p;
    logic out_n;
    // state decodes kept as flops so the status pins never glitch
    logic stopped;
    logic down;
  } bcms_state_s;

  bcms_state_s st_reg;
  bcms_state_s st_next;

  bcms_phase_if ph ();

  logic [PIN_N-1:0] filt_next;
  logic [HALF_W-1:0] half_len;

  // ****************************************
  // pin filtering
  // ****************************************
  // a pin change is taken once stages two and three agree;
  // stage one feeds stage two only, for metastability
  // limitation: a pin is acted on about four edges after it moves,
  // so the short stop and restart reaction figures hold only when
  // counted from the filtered pin, not from the raw one
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      assign filt_next[gi] = (st_reg.s2[gi] == st_reg.s3[gi]) ?
                             st_reg.s3[gi] : st_reg.filt[gi];
    end
  endgenerate

  // edge pulses for the phase detector
  assign ph.proc_rise = filt_next[PIN_PROC] & ~st_reg.filt[PIN_PROC];
  assign ph.chan_rise = filt_next[PIN_CHAN] & ~st_reg.filt[PIN_CHAN];

  // detector works on the filtered pins, all in this one clock
  bcms_phase_det u_phase_det (
    .core_clk (core_clk),
    .sys_rst (sys_rst),
    .pd (ph.det)
  );

  // ****************************************
  // half period per ratio setting
  // ****************************************
  // ratio 00 is the fastest setting, 11 the slowest
  always_comb begin
    case (st_reg.ratio)
      2'b00: half_len = HALF_R0;
      2'b01: half_len = HALF_R1;
      2'b10: half_len = HALF_R2;
      2'b11: half_len = HALF_R3;
      default: half_len = HALF_R0;
    endcase
  end

  // ****************************************
  // mode sequencer, divider and lock tracking
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.s1 = {channel_clock_divided, processor_clock_divided,
                  ratio_select_1, ratio_select_0,
                  clock_stop_n, power_down_n};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.filt = filt_next;

    // bus clock divider, frozen outside the running states so
    // the phase is kept across a stop
    if (st_reg.st == ST_SETTLE || st_reg.st == ST_NORMAL ||
        st_reg.st == ST_RATIO) begin
      if (st_reg.half_cnt == '0) begin
        st_next.clk_p = ~st_reg.clk_p;
        // one cycle shorter or longer to walk the phase;
        // limitation: one core cycle per half period is the finest
        // trim, so a finer window needs a faster core clock
        if (st_reg.adv && half_len > 4'h1) begin
          st_next.half_cnt = half_len - 4'h2;
        end else if (st_reg.slip) begin
          st_next.half_cnt = half_len;
        end else begin
          st_next.half_cnt = half_len - 4'h1;
        end
        st_next.adv = 1'b0;
        st_next.slip = 1'b0;
        // first rising edge after a stop: phase is as before
        if (!st_reg.clk_p && st_reg.clk_en) begin
          st_next.restored = 1'b1;
        end
      end else begin
        st_next.half_cnt = st_reg.half_cnt - 4'h1;
      end
    end

    // power-down wins over every other pin, clock-stop included
    if (!filt_next[PIN_PDN]) begin
      st_next.st = ST_PDN;
      st_next.clk_en = 1'b0;
      st_next.settled = 1'b0;
      st_next.lock = 1'b0;
      st_next.lock_to = 1'b0;
      st_next.restored = 1'b0;
      st_next.timer = '0;
    end else begin
      case (st_reg.st)
        ST_PDN: begin
          // wake: restart the settle timer; ratio pins are taken
          // here so a change made while down lands cleanly
          st_next.st = ST_SETTLE;
          st_next.timer = TIMER_W'(SETTLE_CYCLES);
          st_next.ratio = filt_next[PIN_R1:PIN_R0];
        end
        ST_SETTLE: begin
          if (st_reg.timer <= 20'h00001) begin
            // output declared settled; lock search starts
            st_next.st = ST_NORMAL;
            st_next.clk_en = 1'b1;
            st_next.settled = 1'b1;
            st_next.restored = 1'b1;
            st_next.lock_timer = TIMER_W'(LOCK_CYCLES);
            st_next.timer = '0;
          end else begin
            st_next.timer = st_reg.timer - 20'h00001;
          end
        end
        ST_NORMAL: begin
          if (filt_next[PIN_R1:PIN_R0] != st_reg.ratio) begin
            st_next.st = ST_RATIO;
            st_next.ratio = filt_next[PIN_R1:PIN_R0];
            st_next.timer = TIMER_W'(RATIO_CYCLES);
            st_next.settled = 1'b0;
            st_next.lock = 1'b0;
          end else if (!filt_next[PIN_STOP]) begin
            // output off on the next edge, divider frozen;
            // the far side ends the stop in time, so the
            // held phase is still good on return
            st_next.st = ST_STOP;
            st_next.clk_en = 1'b0;
            st_next.restored = 1'b0;
          end
        end
        ST_RATIO: begin
          // lock search restarts from a full timer after a resettle
          if (st_reg.timer <= 20'h00001) begin
            st_next.st = ST_NORMAL;
            st_next.settled = 1'b1;
            st_next.lock_timer = TIMER_W'(LOCK_CYCLES);
            st_next.lock_to = 1'b0;
            st_next.timer = '0;
          end else begin
            st_next.timer = st_reg.timer - 20'h00001;
          end
        end
        ST_STOP: begin
          if (filt_next[PIN_STOP]) begin
            // edges resume from the held divider phase; a stop
            // held longer than allowed may drift, which is not
            // watched here
            st_next.st = ST_NORMAL;
            st_next.clk_en = 1'b1;
          end
        end
        default: begin
          st_next.st = ST_SETTLE;
          st_next.timer = TIMER_W'(SETTLE_CYCLES);
        end
      endcase
    end

    // distributed loop: judge and correct on each comparison;
    // judged only while normal holds across this edge, else lock
    // could rise on the same edge as a stop, a ratio change or a
    // power-down and be seen without a settled output
    if (st_reg.st == ST_NORMAL && st_next.st == ST_NORMAL &&
        st_reg.settled) begin
      if (ph.err_valid) begin
        st_next.lock = ph.in_window;
        // outside the window always correct; while tracking a
        // spreading reference also trim inside it, which keeps
        // the wander from leaving the window
        if (!ph.in_window || (spread_spectrum_reference &&
            ph.err != '0)) begin
          st_next.adv = (ph.err > 0);
          st_next.slip = (ph.err < 0);
        end
      end
      // timeout only while the fresh verdict is still unlocked, so
      // the flag never rises on the very edge that lock is won
      if (!st_next.lock) begin
        if (st_reg.lock_timer != '0) begin
          st_next.lock_timer = st_reg.lock_timer - 20'h00001;
        end else begin
          st_next.lock_to = 1'b1;
        end
      end
    end

    // registered output pair, quiet when disabled
    st_next.out_p = st_next.clk_en & st_next.clk_p;
    st_next.out_n = st_next.clk_en & ~st_next.clk_p;
    // status decodes of the next state, registered with it
    st_next.stopped = (st_next.st == ST_STOP);
    st_next.down = (st_next.st == ST_PDN);
  end

  // ****************************************
  // state register
  // ****************************************
  // reset is the power-up event: start settling at once;
  // pin stages preset to idle levels so no false power-down or
  // stop is seen right after reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.st <= ST_SETTLE;
      st_reg.s1 <= PIN_RESET;
      st_reg.s2 <= PIN_RESET;
      st_reg.s3 <= PIN_RESET;
      st_reg.filt <= PIN_RESET;
      st_reg.timer <= TIMER_W'(SETTLE_CYCLES);
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs, straight from the state register
  // ****************************************
  assign bus_clock_pair_p = st_reg.out_p;
  assign bus_clock_pair_n = st_reg.out_n;
  assign clock_stopped_state = st_reg.stopped;
  assign powered_down = st_reg.down;
  assign output_settled = st_reg.settled;
  assign phase_restored = st_reg.restored;
  assign distributed_loop_lock = st_reg.lock;
  assign lock_timeout = st_reg.lock_to;

endmodule // bcms_sequencer
`default_nettype wire

// ===== src/bcms_pkg.sv
`default_nettype none
package bcms_pkg;

  // ****************************************
  // clock and timing figures
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int SETTLE_MS = 3;
  localparam int RATIO_MS = 1;
  localparam int LOCK_MS = 5;
  localparam int CLKON_NS = 10;
  localparam int CLKOFF_NS = 5;
  localparam int PHASE_WIN_PS = 100;
  localparam int PS_PER_NS = 1000;
  localparam int RESTORE_MAX_CYC = 20;
  // all times round down; only the clock-on and clock-off times are held at one cycle or more
  localparam int SETTLE_CYC = SETTLE_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int RATIO_CYC = RATIO_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int LOCK_CYC = LOCK_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int CLKON_CYC = (CLKON_NS / CLK_PERIOD_NS < 1) ? 1 :
                             CLKON_NS / CLK_PERIOD_NS;
  localparam int CLKOFF_CYC = (CLKOFF_NS / CLK_PERIOD_NS < 1) ? 1 :
                              CLKOFF_NS / CLK_PERIOD_NS;
  // lock window in whole clock cycles, rounded down
  localparam int PHASE_WIN_CYC = PHASE_WIN_PS /
                                 (CLK_PERIOD_NS * PS_PER_NS);

  // ****************************************
  // widths, pin indices, divider table
  // ****************************************
  localparam int TIMER_W = 20;
  localparam int HALF_W = 4;
  localparam int PIN_N = 6;
  localparam int PIN_PDN = 0;
  localparam int PIN_STOP = 1;
  localparam int PIN_R0 = 2;
  localparam int PIN_R1 = 3;
  localparam int PIN_PROC = 4;
  localparam int PIN_CHAN = 5;
  localparam logic [HALF_W-1:0] HALF_R0 = 4'h2;
  localparam logic [HALF_W-1:0] HALF_R1 = 4'h3;
  localparam logic [HALF_W-1:0] HALF_R2 = 4'h4;
  localparam logic [HALF_W-1:0] HALF_R3 = 4'h5;
  localparam logic [PIN_N-1:0] PIN_RESET = 6'h03;
  localparam logic [6:0] PD_CNT_MAX = 7'h7F;

  typedef logic signed [7:0] bcms_err_t;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b000,
    ST_NORMAL = 3'b001,
    ST_RATIO  = 3'b010,
    ST_STOP   = 3'b011,
    ST_PDN    = 3'b100
  } bcms_state_e;

endpackage
`default_nettype wire

// ===== src/bcms_phase_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bcms_phase_if;
  import bcms_pkg::*;
  logic proc_rise;
  logic chan_rise;
  bcms_err_t err;
  logic err_valid;
  logic in_window;
  modport det (input proc_rise, input chan_rise,
               output err, output err_valid, output in_window);
  modport ctl (output proc_rise, output chan_rise,
               input err, input err_valid, input in_window);
endinterface
`default_nettype wire

// ===== src/bcms_phase_det.sv
`timescale 1ns/1ps
`default_nettype none
module bcms_phase_det import bcms_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // edge pulses in, error out
  bcms_phase_if.det pd
);

  typedef struct packed {
    logic [6:0] cnt;
    logic last_chan;
    bcms_err_t err;
    logic valid;
    logic win;
  } bcms_pd_s;

  bcms_pd_s pd_reg;
  bcms_pd_s pd_next;

  // ****************************************
  // signed edge distance, channel minus processor
  // ****************************************
  always_comb begin
    pd_next = pd_reg;
    pd_next.valid = 1'b0;
    if (pd_reg.cnt != PD_CNT_MAX) begin
      pd_next.cnt = pd_reg.cnt + 7'h01;
    end
    if (pd.proc_rise && pd.chan_rise) begin
      pd_next.err = '0;
      pd_next.valid = 1'b1;
      pd_next.cnt = '0;
    end else if (pd.proc_rise) begin
      // channel edge came first: channel leads
      if (pd_reg.last_chan) begin
        pd_next.err = -$signed({1'b0, pd_reg.cnt});
        pd_next.valid = 1'b1;
      end
      pd_next.last_chan = 1'b0;
      pd_next.cnt = '0;
    end else if (pd.chan_rise) begin
      if (!pd_reg.last_chan) begin
        pd_next.err = $signed({1'b0, pd_reg.cnt});
        pd_next.valid = 1'b1;
      end
      pd_next.last_chan = 1'b1;
      pd_next.cnt = '0;
    end
    // window check on the fresh error only
    if (pd_next.valid) begin
      pd_next.win = (pd_next.err <= 8'(PHASE_WIN_CYC)) &&
                    (pd_next.err >= -8'(PHASE_WIN_CYC));
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pd_reg <= '0;
    end else begin
      pd_reg <= pd_next;
    end
  end

  assign pd.err = pd_reg.err;
  assign pd.err_valid = pd_reg.valid;
  assign pd.in_window = pd_reg.win;

endmodule // bcms_phase_det
`default_nettype wire

// ===== tb/bcms_gear_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// gear logic stand-in: divided clocks
// ****************************************
module bcms_gear_model (
  // clock
  input wire logic core_clk,
  // channel lag in core cycles, 0 = aligned
  input wire logic [1:0] skew,
  // divided clocks toward the sequencer
  output logic proc_div,
  output logic chan_div
);
  logic [3:0] cnt_reg = 4'h0;
  logic [3:0] hist_reg = 4'h0;
  // free-running divide by 16, channel copy delayed by skew
  always_ff @(posedge core_clk) begin
    cnt_reg <= cnt_reg + 4'h1;
    hist_reg <= {hist_reg[2:0], cnt_reg[3]};
  end
  assign proc_div = cnt_reg[3];
  // fixed lag: the far side never follows the trims, so lock holds steady only at skew 0; skew 1 locks until each processor edge
  assign chan_div = (skew == 2'h0) ? cnt_reg[3] : hist_reg[skew - 2'h1];
endmodule // bcms_gear_model
`default_nettype wire

// ===== tb/bcms_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bcms_sequencer_asserts import bcms_pkg::*; #(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned RATIO_CYCLES = RATIO_CYC,
  parameter int unsigned LOCK_CYCLES = LOCK_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // mode pins
  input wire logic power_down_n,
  input wire logic clock_stop_n,
  input wire logic ratio_select_0,
  input wire logic ratio_select_1,
  input wire logic spread_spectrum_reference,
  // divided clocks
  input wire logic processor_clock_divided,
  input wire logic channel_clock_divided,
  // bus clock pair
  input wire logic bus_clock_pair_p,
  input wire logic bus_clock_pair_n,
  // status
  input wire logic clock_stopped_state,
  input wire logic powered_down,
  input wire logic output_settled,
  input wire logic phase_restored,
  input wire logic distributed_loop_lock,
  input wire logic lock_timeout
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  int unsigned wait_reg;
  // cycles spent unsettled while running; slack covers the pin filter
  always_ff @(posedge core_clk) begin
    if (sys_rst || output_settled || powered_down || clock_stopped_state) begin
      wait_reg <= 0;
    end else begin
      wait_reg <= wait_reg + 1;
    end
  end
  AST_SETTLE_BOUND: assert property (wait_reg <= SETTLE_CYCLES + 8)
    else $error("settling took too long");
  AST_STOP_ENTRY: assert property ($fell(clock_stop_n) && power_down_n
    && output_settled && !clock_stopped_state && !powered_down
    |-> ##[1:6] clock_stopped_state) else $error("stop not entered");
  AST_STOP_EXIT: assert property ($rose(clock_stop_n) && power_down_n
    && clock_stopped_state |-> ##[1:6] !clock_stopped_state)
    else $error("stop not left");
  AST_PDN_ENTRY: assert property ($fell(power_down_n)
    |-> ##[1:6] powered_down) else $error("power-down not entered");
  AST_QUIET: assert property (clock_stopped_state || powered_down
    |-> !bus_clock_pair_p && !bus_clock_pair_n)
    else $error("pair driven while disabled");
  AST_TOGGLE: assert property ($rose(output_settled) && !clock_stopped_state
    |-> ##[0:6] $changed(bus_clock_pair_p)) else $error("pair idle after settling");
  AST_RESTORE: assert property ($fell(clock_stopped_state) && !powered_down
    |-> ##[0:12] phase_restored) else $error("phase not restored");
  AST_LOCK_FLAG: assert property ($rose(lock_timeout)
    |-> !distributed_loop_lock) else $error("timeout while locked");
  AST_LOCK_SETTLED: assert property ($rose(distributed_loop_lock)
    |-> output_settled && !clock_stopped_state) else $error("lock before settle");
  // main scenarios
  COV_STOP: cover property ($fell(clock_stopped_state));
  COV_LOCK: cover property ($rose(distributed_loop_lock));
  COV_TIMEOUT: cover property ($rose(lock_timeout));
endmodule // bcms_sequencer_asserts
bind bcms_sequencer bcms_sequencer_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES),
  .RATIO_CYCLES(RATIO_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) u_chk (.core_clk,
  .sys_rst, .power_down_n, .clock_stop_n, .ratio_select_0, .ratio_select_1,
  .spread_spectrum_reference, .processor_clock_divided, .channel_clock_divided,
  .bus_clock_pair_p, .bus_clock_pair_n, .clock_stopped_state, .powered_down,
  .output_settled, .phase_restored, .distributed_loop_lock, .lock_timeout);
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bcms_pkg::*;
  // ****************************************
  // pins, status and counters
  // ****************************************
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic power_down_n = 1'b1;
  logic clock_stop_n = 1'b1;
  logic ratio_select_0 = 1'b0;
  logic ratio_select_1 = 1'b0;
  logic spread_spectrum_reference = 1'b0;
  logic [1:0] skew = 2'h0;
  logic proc_div, chan_div, clk_p, clk_n, lock_to;
  logic stopped, down, settled, restored, lock;
  wire logic [4:0] stat;
  int err_count = 0;
  int checks_done = 0;
  int h;
  typedef struct {logic [1:0] sel; int half;} bcms_row_s;
  // every row changes the ratio; half period in core cycles
  bcms_row_s rows[4] = '{'{2'h1, 3}, '{2'h2, 4}, '{2'h3, 5}, '{2'h0, 2}};
  assign stat = {lock, restored, settled, down, stopped};
  always #5 core_clk = ~core_clk;
  bcms_gear_model gear (.core_clk(core_clk), .skew(skew),
    .proc_div(proc_div), .chan_div(chan_div));
  bcms_sequencer #(.SETTLE_CYCLES(50), .RATIO_CYCLES(20), .LOCK_CYCLES(200))
    dut (.core_clk(core_clk), .sys_rst(sys_rst), .power_down_n(power_down_n),
    .clock_stop_n(clock_stop_n), .ratio_select_0(ratio_select_0),
    .ratio_select_1(ratio_select_1),
    .spread_spectrum_reference(spread_spectrum_reference),
    .processor_clock_divided(proc_div), .channel_clock_divided(chan_div),
    .bus_clock_pair_p(clk_p), .bus_clock_pair_n(clk_n),
    .clock_stopped_state(stopped), .powered_down(down),
    .output_settled(settled), .phase_restored(restored),
    .distributed_loop_lock(lock), .lock_timeout(lock_to));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // inputs move 1 ns after the edge so the sample is never racy
  task automatic step(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  // bounded wait on one status bit; a lapse ends the run
  task automatic wait_stat(input int idx, input logic v, input int lim);
    int k;
    k = 0;
    while (stat[idx] !== v && k < lim) begin
      step(1);
      k++;
    end
    chk($sformatf("status bit %0d", idx), {7'h0, v}, {7'h0, stat[idx]});
    if (stat[idx] !== v) tally_and_finish;
  endtask
  // cycles between two changes of the positive output
  task automatic half_of(output int n);
    logic last;
    int k;
    last = clk_p;
    k = 0;
    while (clk_p === last && k < 20) begin step(1); k++; end
    last = clk_p;
    n = 0;
    while (clk_p === last && n < 20) begin step(1); n++; end
    // a pair that never toggles is a lapse: count it and stop
    if (n >= 20) begin
      chk("pair toggle", 8'h1, 8'h0);
      tally_and_finish;
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    step(12);
    sys_rst = 1'b0;
    chk("settled at reset", 8'h0, {7'h0, settled});
    wait_stat(2, 1'b1, 60);
    foreach (rows[i]) begin
      {ratio_select_1, ratio_select_0} = rows[i].sel;
      wait_stat(2, 1'b0, 8);
      wait_stat(2, 1'b1, 30);
      half_of(h);
      chk("half period", rows[i].half[7:0], h[7:0]);
      chk("pair complement", {7'h0, ~clk_p}, {7'h0, clk_n});
    end
    wait_stat(4, 1'b1, 250);
    spread_spectrum_reference = 1'b1;
    step(40);
    chk("lock while tracking", 8'h1, {6'h0, lock_to, lock});
    skew = 2'h2;
    step(60);
    chk("lock with skew", 8'h0, {7'h0, lock});
    skew = 2'h0;
    spread_spectrum_reference = 1'b0;
    // gap before the stop is scaled down; the sequencer does not police it
    clock_stop_n = 1'b0;
    wait_stat(0, 1'b1, 8);
    step(20);
    chk("pair in stop", 8'h0, {6'h0, clk_p, clk_n});
    clock_stop_n = 1'b1;
    wait_stat(0, 1'b0, 8);
    wait_stat(3, 1'b1, 12);
    power_down_n = 1'b0;
    clock_stop_n = 1'b0;
    wait_stat(1, 1'b1, 8);
    step(10);
    chk("stop under power-down", 8'h0, {7'h0, stopped});
    chk("pair in power-down", 8'h0, {6'h0, clk_p, clk_n});
    clock_stop_n = 1'b1;
    power_down_n = 1'b1;
    wait_stat(1, 1'b0, 8);
    wait_stat(2, 1'b1, 65);
    // second reset mid-run, then a loop that can never align
    skew = 2'h2;
    sys_rst = 1'b1;
    step(12);
    sys_rst = 1'b0;
    chk("status after reset", 8'h0, {3'h0, stat});
    wait_stat(2, 1'b1, 60);
    step(215);
    chk("lock timeout", 8'h2, {6'h0, lock_to, lock});
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
